/* design/mac_regmap_map.vh */
`ifndef MAC_REGMAP_MAP_VH
`define MAC_REGMAP_MAP_VH

// ----------------------------------------
// Soft register offsets (bytes from base)
// ----------------------------------------
`define OFF_FILTER_CTL   18'h00000
`define OFF_PAUSE_VAL    18'h00004
`define OFF_GAP_ADJ      18'h00008
`define OFF_IRQ_STAT     18'h0000c
`define OFF_IRQ_PEND     18'h00010
`define OFF_IRQ_EN       18'h00014
`define OFF_TX_TAG       18'h00018
`define OFF_RX_TAG       18'h0001c
`define OFF_SADDR_LO     18'h00020
`define OFF_SADDR_HI     18'h00024
`define OFF_TPID_A       18'h00028
`define OFF_TPID_B       18'h0002c
`define OFF_PCS_STAT     18'h00030
`define OFF_RXCFG_A      18'h00400
`define OFF_RXCFG_B      18'h00404
`define OFF_TXCFG        18'h00408
`define OFF_FLOWCFG      18'h0040c
`define OFF_MODECFG      18'h00410
`define OFF_MG_CFG       18'h00500
`define OFF_MG_CTL       18'h00504
`define OFF_MG_WDATA     18'h00508
`define OFF_MG_RDATA     18'h0050c
`define OFF_MG_IRQ_STAT  18'h00600
`define OFF_MG_IRQ_PEND  18'h00620
`define OFF_MG_IRQ_EN    18'h00640
`define OFF_MG_IRQ_CLR   18'h00660
`define OFF_SWORD_A      18'h00700
`define OFF_SWORD_B      18'h00704
`define OFF_FSEL         18'h00708
`define OFF_AFILT_LO     18'h00710
`define OFF_AFILT_HI     18'h00714

// ----------------------------------------
// Table windows: first and last word
// ----------------------------------------
`define STATS_FIRST      18'h00200
`define STATS_LAST       18'h003fc
`define TXVT_FIRST       18'h04000
`define TXVT_LAST        18'h07ffc
`define RXVT_FIRST       18'h08000
`define RXVT_LAST        18'h0bffc
`define AVB_FIRST        18'h10000
`define AVB_LAST         18'h13ffc
`define GRP_FIRST        18'h20000
`define GRP_LAST         18'h3fffc

// Table select codes
`define TSEL_NONE        3'h0
`define TSEL_STATS       3'h1
`define TSEL_TXVT        3'h2
`define TSEL_RXVT        3'h3
`define TSEL_AVB         3'h4
`define TSEL_GRP         3'h5

// ----------------------------------------
// Filter control fields, write masks, resets
// ----------------------------------------
`define FC_BAD_BIT       14
`define FC_EXT_BIT       12
`define FC_NEW_BIT       11
`define FC_RXUT_LSB      9
`define FC_TXUT_LSB      7
`define FC_RXTI_LSB      5
`define FC_TXTI_LSB      3
`define FC_BCST_BIT      2
`define FC_GRP_BIT       1
`define FC_WMASK         32'h00005ffe
`define MODE_WMASK       32'hc0000000
`define PAUSE_WMASK      32'h0000ffff
`define GAP_WMASK        32'h000000ff
`define FULL_WMASK       32'hffffffff
`define REG_RESET        32'h00000000
`define SEL_RESERVED     2'h2
`define SEL_OFF          2'h0
`define RESP_OKAY        2'h0

`endif

/* design/mac_register_map_and_rx_filter_ctl.v */
`timescale 1ns/1ps
`include "mac_regmap_map.vh"

module mac_register_map_and_rx_filter_ctl #(
    parameter [31:0] map_base_param              = 32'h00000000,
    parameter        build_rx_untag              = 0,
    parameter        build_tx_untag              = 0,
    parameter        build_rx_tag_insert         = 0,
    parameter        build_tx_tag_insert         = 0,
    parameter        build_extended_group_filter = 0
) (
    // Clock and reset
    input  wire        clock_i,
    input  wire        reset_n_i,
    // Register bus, write side
    input  wire [31:0] s_axi_awaddr_i,
    input  wire        s_axi_awvalid_i,
    output wire        s_axi_awready_o,
    input  wire [31:0] s_axi_wdata_i,
    input  wire [3:0]  s_axi_wstrb_i,
    input  wire        s_axi_wvalid_i,
    output wire        s_axi_wready_o,
    output wire [1:0]  s_axi_bresp_o,
    output wire        s_axi_bvalid_o,
    input  wire        s_axi_bready_i,
    // Register bus, read side
    input  wire [31:0] s_axi_araddr_i,
    input  wire        s_axi_arvalid_i,
    output wire        s_axi_arready_o,
    output wire [31:0] s_axi_rdata_o,
    output wire [1:0]  s_axi_rresp_o,
    output wire        s_axi_rvalid_o,
    input  wire        s_axi_rready_i,
    // Status from the MAC core
    input  wire [31:0] serdes_pcs_status_i,
    input  wire [29:0] mode_status_i,
    input  wire [31:0] mgmt_read_data_i,
    // External table port
    output wire [2:0]  table_sel_o,
    output wire [15:0] table_addr_o,
    output wire [31:0] table_wdata_o,
    output wire        table_we_o,
    input  wire [31:0] table_rdata_i,
    // Receive filter controls
    output wire        accept_bad_frames_o,
    output wire        drop_all_broadcast_o,
    output wire        drop_all_group_frames_o,
    output wire        extended_group_filter_on_o,
    // VLAN controls
    output wire [1:0]  rx_untag_select_o,
    output wire [1:0]  tx_untag_select_o,
    output wire [1:0]  rx_tag_insert_select_o,
    output wire [1:0]  tx_tag_insert_select_o,
    output wire [31:0] rx_vlan_tag_value_o,
    output wire [31:0] tx_vlan_tag_value_o,
    output wire [31:0] tag_protocol_id_a_o,
    output wire [31:0] tag_protocol_id_b_o,
    // Pause request
    output wire [15:0] tx_pause_value_o,
    output wire        tx_pause_write_o
);

// ----------------------------------------
// Bus state machine
// ----------------------------------------
localparam [1:0] ST_IDLE    = 2'h0;
localparam [1:0] ST_RD_LOOK = 2'h1;
localparam [1:0] ST_RD_RESP = 2'h2;
localparam [1:0] ST_WR_RESP = 2'h3;

reg  [1:0]  state_reg;
reg  [1:0]  state_next;
reg  [17:0] rd_off_reg;
reg  [31:0] rdata_reg;
reg  [31:0] rd_mux;
reg  [2:0]  tsel_reg;
reg  [15:0] taddr_reg;
reg  [31:0] twdata_reg;
reg         twe_reg;
reg         pause_wr_reg;

// Soft registers
reg  [31:0] filter_ctl_reg;
reg  [31:0] pause_val_reg;
reg  [31:0] gap_adj_reg;
reg  [31:0] irq_stat_reg;
reg  [31:0] irq_en_reg;
reg  [31:0] tx_tag_reg;
reg  [31:0] rx_tag_reg;
reg  [31:0] saddr_lo_reg;
reg  [31:0] saddr_hi_reg;
reg  [31:0] tpid_a_reg;
reg  [31:0] tpid_b_reg;
reg  [31:0] rxcfg_a_reg;
reg  [31:0] rxcfg_b_reg;
reg  [31:0] txcfg_reg;
reg  [31:0] flowcfg_reg;
reg  [31:0] mode_reg;
reg  [31:0] mg_cfg_reg;
reg  [31:0] mg_ctl_reg;
reg  [31:0] mg_wdata_reg;
reg  [31:0] mg_irq_stat_reg;
reg  [31:0] mg_irq_en_reg;
reg  [31:0] mg_irq_clr_reg;
reg  [31:0] sword_a_reg;
reg  [31:0] sword_b_reg;
reg  [31:0] fsel_reg;
reg  [31:0] afilt_lo_reg;
reg  [31:0] afilt_hi_reg;

// Effective controls; VLAN selects and extended filter after build gating
reg         bad_eff_reg;
reg         bcst_eff_reg;
reg         grp_eff_reg;
reg         ext_eff_reg;
reg  [1:0]  rxut_eff_reg;
reg  [1:0]  txut_eff_reg;
reg  [1:0]  rxti_eff_reg;
reg  [1:0]  txti_eff_reg;

wire        in_map_wr;
wire        in_map_rd;
wire [17:0] wr_off;
wire [17:0] rd_off;
wire        wr_take;
wire        rd_take;
wire [31:0] strb_mask;
wire        new_on;

// ----------------------------------------
// Address decode helpers
// ----------------------------------------
// Which table window an offset falls in
function [2:0] table_of;
    input [17:0] off;
    begin
        if (off >= `GRP_FIRST && off <= `GRP_LAST)
            table_of = `TSEL_GRP;
        else if (off >= `AVB_FIRST && off <= `AVB_LAST)
            table_of = `TSEL_AVB;
        else if (off >= `RXVT_FIRST && off <= `RXVT_LAST)
            table_of = `TSEL_RXVT;
        else if (off >= `TXVT_FIRST && off <= `TXVT_LAST)
            table_of = `TSEL_TXVT;
        else if (off >= `STATS_FIRST && off <= `STATS_LAST)
            table_of = `TSEL_STATS;
        else
            table_of = `TSEL_NONE;
    end
endfunction

// Word index from offset bits 16:2; starts at 0 only in the group window; windows are 2^n aligned
function [15:0] table_index;
    input [17:0] off;
    begin
        table_index = off[17:2] & 16'h7fff;
    end
endfunction

// Merge write data under strobe and writable-bit masks
function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [31:0] wm;
    begin
        merge = (old & ~wm) | (wd & wm);
    end
endfunction

// Fixed offsets from the build-time base; low two bits ignored
assign in_map_wr = (s_axi_awaddr_i[31:18] == map_base_param[31:18]);
assign in_map_rd = (s_axi_araddr_i[31:18] == map_base_param[31:18]);
assign wr_off    = {s_axi_awaddr_i[17:2], 2'b00};
assign rd_off    = {s_axi_araddr_i[17:2], 2'b00};

// Address and data must arrive together; writes win over reads
assign wr_take   = (state_reg == ST_IDLE) && s_axi_awvalid_i && s_axi_wvalid_i;
assign rd_take   = (state_reg == ST_IDLE) && !wr_take && s_axi_arvalid_i;

assign strb_mask = {{8{s_axi_wstrb_i[3]}}, {8{s_axi_wstrb_i[2]}},
                    {8{s_axi_wstrb_i[1]}}, {8{s_axi_wstrb_i[0]}}};

// ----------------------------------------
// Bus handshakes and responses
// ----------------------------------------
assign s_axi_awready_o = wr_take;
assign s_axi_wready_o  = wr_take;
assign s_axi_arready_o = rd_take;
assign s_axi_bvalid_o  = (state_reg == ST_WR_RESP);
assign s_axi_rvalid_o  = (state_reg == ST_RD_RESP);
assign s_axi_bresp_o   = `RESP_OKAY;
assign s_axi_rresp_o   = `RESP_OKAY;
assign s_axi_rdata_o   = rdata_reg;

// Next state
always @* begin
    state_next = state_reg;
    case (state_reg)
        ST_IDLE: begin
            if (wr_take)
                state_next = ST_WR_RESP;
            else if (rd_take)
                state_next = ST_RD_LOOK;
        end
        ST_RD_LOOK: begin
            state_next = ST_RD_RESP;
        end
        ST_RD_RESP: begin
            if (s_axi_rready_i)
                state_next = ST_IDLE;
        end
        ST_WR_RESP: begin
            if (s_axi_bready_i)
                state_next = ST_IDLE;
        end
        default: begin
            state_next = ST_IDLE;
        end
    endcase
end

// State, latched read offset, table port
always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        state_reg    <= ST_IDLE;
        rd_off_reg   <= 18'h00000;
        tsel_reg     <= `TSEL_NONE;
        taddr_reg    <= 16'h0000;
        twdata_reg   <= `REG_RESET;
        twe_reg      <= 1'b0;
        pause_wr_reg <= 1'b0;
    end else begin
        state_reg    <= state_next;
        twe_reg      <= 1'b0;
        pause_wr_reg <= 1'b0;
        if (rd_take) begin
            rd_off_reg <= rd_off;
            tsel_reg   <= in_map_rd ? table_of(rd_off) : `TSEL_NONE;
            taddr_reg  <= table_index(rd_off);
        end
        if (wr_take) begin
            tsel_reg   <= in_map_wr ? table_of(wr_off) : `TSEL_NONE;
            taddr_reg  <= table_index(wr_off);
            twdata_reg <= s_axi_wdata_i;
            // Statistics are read-only; tables take whole words only
            twe_reg    <= in_map_wr && (table_of(wr_off) != `TSEL_NONE)
                          && (table_of(wr_off) != `TSEL_STATS);
            pause_wr_reg <= in_map_wr && (wr_off == `OFF_PAUSE_VAL);
        end
    end
end

assign table_sel_o      = tsel_reg;
assign table_addr_o     = taddr_reg;
assign table_wdata_o    = twdata_reg;
assign table_we_o       = twe_reg;
assign tx_pause_write_o = pause_wr_reg;

// ----------------------------------------
// Register writes
// ----------------------------------------
// Every register clears at reset, so added functions start off
always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        filter_ctl_reg  <= `REG_RESET;
        pause_val_reg   <= `REG_RESET;
        gap_adj_reg     <= `REG_RESET;
        irq_stat_reg    <= `REG_RESET;
        irq_en_reg      <= `REG_RESET;
        tx_tag_reg      <= `REG_RESET;
        rx_tag_reg      <= `REG_RESET;
        saddr_lo_reg    <= `REG_RESET;
        saddr_hi_reg    <= `REG_RESET;
        tpid_a_reg      <= `REG_RESET;
        tpid_b_reg      <= `REG_RESET;
        rxcfg_a_reg     <= `REG_RESET;
        rxcfg_b_reg     <= `REG_RESET;
        txcfg_reg       <= `REG_RESET;
        flowcfg_reg     <= `REG_RESET;
        mode_reg        <= `REG_RESET;
        mg_cfg_reg      <= `REG_RESET;
        mg_ctl_reg      <= `REG_RESET;
        mg_wdata_reg    <= `REG_RESET;
        mg_irq_stat_reg <= `REG_RESET;
        mg_irq_en_reg   <= `REG_RESET;
        mg_irq_clr_reg  <= `REG_RESET;
        sword_a_reg     <= `REG_RESET;
        sword_b_reg     <= `REG_RESET;
        fsel_reg        <= `REG_RESET;
        afilt_lo_reg    <= `REG_RESET;
        afilt_hi_reg    <= `REG_RESET;
    end else if (wr_take && in_map_wr) begin
        case (wr_off)
            `OFF_FILTER_CTL:
                filter_ctl_reg <= merge(filter_ctl_reg, s_axi_wdata_i,
                                        strb_mask & `FC_WMASK);
            `OFF_PAUSE_VAL:
                pause_val_reg <= merge(pause_val_reg, s_axi_wdata_i,
                                       strb_mask & `PAUSE_WMASK);
            `OFF_GAP_ADJ:
                gap_adj_reg <= merge(gap_adj_reg, s_axi_wdata_i,
                                     strb_mask & `GAP_WMASK);
            `OFF_IRQ_STAT:
                irq_stat_reg <= merge(irq_stat_reg, s_axi_wdata_i, strb_mask);
            `OFF_IRQ_EN:
                irq_en_reg <= merge(irq_en_reg, s_axi_wdata_i, strb_mask);
            `OFF_TX_TAG:
                tx_tag_reg <= merge(tx_tag_reg, s_axi_wdata_i, strb_mask);
            `OFF_RX_TAG:
                rx_tag_reg <= merge(rx_tag_reg, s_axi_wdata_i, strb_mask);
            `OFF_SADDR_LO:
                saddr_lo_reg <= merge(saddr_lo_reg, s_axi_wdata_i, strb_mask);
            `OFF_SADDR_HI:
                saddr_hi_reg <= merge(saddr_hi_reg, s_axi_wdata_i, strb_mask);
            `OFF_TPID_A:
                tpid_a_reg <= merge(tpid_a_reg, s_axi_wdata_i, strb_mask);
            `OFF_TPID_B:
                tpid_b_reg <= merge(tpid_b_reg, s_axi_wdata_i, strb_mask);
            `OFF_RXCFG_A:
                rxcfg_a_reg <= merge(rxcfg_a_reg, s_axi_wdata_i, strb_mask);
            `OFF_RXCFG_B:
                rxcfg_b_reg <= merge(rxcfg_b_reg, s_axi_wdata_i, strb_mask);
            `OFF_TXCFG:
                txcfg_reg <= merge(txcfg_reg, s_axi_wdata_i, strb_mask);
            `OFF_FLOWCFG:
                flowcfg_reg <= merge(flowcfg_reg, s_axi_wdata_i, strb_mask);
            `OFF_MODECFG:
                mode_reg <= merge(mode_reg, s_axi_wdata_i,
                                  strb_mask & `MODE_WMASK);
            `OFF_MG_CFG:
                mg_cfg_reg <= merge(mg_cfg_reg, s_axi_wdata_i, strb_mask);
            `OFF_MG_CTL:
                mg_ctl_reg <= merge(mg_ctl_reg, s_axi_wdata_i, strb_mask);
            `OFF_MG_WDATA:
                mg_wdata_reg <= merge(mg_wdata_reg, s_axi_wdata_i, strb_mask);
            `OFF_MG_IRQ_STAT:
                mg_irq_stat_reg <= merge(mg_irq_stat_reg, s_axi_wdata_i,
                                         strb_mask);
            `OFF_MG_IRQ_EN:
                mg_irq_en_reg <= merge(mg_irq_en_reg, s_axi_wdata_i, strb_mask);
            `OFF_MG_IRQ_CLR:
                mg_irq_clr_reg <= merge(mg_irq_clr_reg, s_axi_wdata_i,
                                        strb_mask);
            `OFF_SWORD_A:
                sword_a_reg <= merge(sword_a_reg, s_axi_wdata_i, strb_mask);
            `OFF_SWORD_B:
                sword_b_reg <= merge(sword_b_reg, s_axi_wdata_i, strb_mask);
            `OFF_FSEL:
                fsel_reg <= merge(fsel_reg, s_axi_wdata_i, strb_mask);
            `OFF_AFILT_LO:
                afilt_lo_reg <= merge(afilt_lo_reg, s_axi_wdata_i, strb_mask);
            `OFF_AFILT_HI:
                afilt_hi_reg <= merge(afilt_hi_reg, s_axi_wdata_i, strb_mask);
            // Read-only words and holes drop the write
            default: begin
            end
        endcase
    end
end

// ----------------------------------------
// Read data mux
// ----------------------------------------
// Table data is looked up one cycle after the address is latched
always @* begin
    rd_mux = `REG_RESET;
    case (rd_off_reg)
        `OFF_FILTER_CTL:  rd_mux = filter_ctl_reg;
        `OFF_PAUSE_VAL:   rd_mux = pause_val_reg;
        `OFF_GAP_ADJ:     rd_mux = gap_adj_reg;
        `OFF_IRQ_STAT:    rd_mux = irq_stat_reg;
        `OFF_IRQ_PEND:    rd_mux = irq_stat_reg & irq_en_reg;
        `OFF_IRQ_EN:      rd_mux = irq_en_reg;
        `OFF_TX_TAG:      rd_mux = tx_tag_reg;
        `OFF_RX_TAG:      rd_mux = rx_tag_reg;
        `OFF_SADDR_LO:    rd_mux = saddr_lo_reg;
        `OFF_SADDR_HI:    rd_mux = saddr_hi_reg;
        `OFF_TPID_A:      rd_mux = tpid_a_reg;
        `OFF_TPID_B:      rd_mux = tpid_b_reg;
        `OFF_PCS_STAT:    rd_mux = serdes_pcs_status_i;
        `OFF_RXCFG_A:     rd_mux = rxcfg_a_reg;
        `OFF_RXCFG_B:     rd_mux = rxcfg_b_reg;
        `OFF_TXCFG:       rd_mux = txcfg_reg;
        `OFF_FLOWCFG:     rd_mux = flowcfg_reg;
        `OFF_MODECFG:     rd_mux = {mode_reg[31:30], mode_status_i};
        `OFF_MG_CFG:      rd_mux = mg_cfg_reg;
        `OFF_MG_CTL:      rd_mux = mg_ctl_reg;
        `OFF_MG_WDATA:    rd_mux = mg_wdata_reg;
        `OFF_MG_RDATA:    rd_mux = mgmt_read_data_i;
        `OFF_MG_IRQ_STAT: rd_mux = mg_irq_stat_reg;
        `OFF_MG_IRQ_PEND: rd_mux = mg_irq_stat_reg & mg_irq_en_reg;
        `OFF_MG_IRQ_EN:   rd_mux = mg_irq_en_reg;
        `OFF_MG_IRQ_CLR:  rd_mux = mg_irq_clr_reg;
        `OFF_SWORD_A:     rd_mux = sword_a_reg;
        `OFF_SWORD_B:     rd_mux = sword_b_reg;
        `OFF_FSEL:        rd_mux = fsel_reg;
        `OFF_AFILT_LO:    rd_mux = afilt_lo_reg;
        `OFF_AFILT_HI:    rd_mux = afilt_hi_reg;
        default: begin
            if (tsel_reg != `TSEL_NONE)
                rd_mux = table_rdata_i;
        end
    endcase
end

// Read data holds until the next read
always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i)
        rdata_reg <= `REG_RESET;
    else if (state_reg == ST_RD_LOOK)
        rdata_reg <= rd_mux;
end

// ----------------------------------------
// Effective filter and VLAN controls
// ----------------------------------------
// Reserved untag select codes act as off; registered to keep outputs clean
assign new_on = filter_ctl_reg[`FC_NEW_BIT];

always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        bad_eff_reg  <= 1'b0;
        bcst_eff_reg <= 1'b0;
        grp_eff_reg  <= 1'b0;
        ext_eff_reg  <= 1'b0;
        rxut_eff_reg <= `SEL_OFF;
        txut_eff_reg <= `SEL_OFF;
        rxti_eff_reg <= `SEL_OFF;
        txti_eff_reg <= `SEL_OFF;
    end else begin
        bad_eff_reg  <= filter_ctl_reg[`FC_BAD_BIT];
        bcst_eff_reg <= filter_ctl_reg[`FC_BCST_BIT];
        grp_eff_reg  <= filter_ctl_reg[`FC_GRP_BIT];
        ext_eff_reg  <= (build_extended_group_filter != 0) && new_on
                        && filter_ctl_reg[`FC_EXT_BIT];
        rxut_eff_reg <= `SEL_OFF;
        txut_eff_reg <= `SEL_OFF;
        rxti_eff_reg <= `SEL_OFF;
        txti_eff_reg <= `SEL_OFF;
        if ((build_rx_untag != 0) && new_on &&
            filter_ctl_reg[`FC_RXUT_LSB +: 2] != `SEL_RESERVED)
            rxut_eff_reg <= filter_ctl_reg[`FC_RXUT_LSB +: 2];
        if ((build_tx_untag != 0) && new_on &&
            filter_ctl_reg[`FC_TXUT_LSB +: 2] != `SEL_RESERVED)
            txut_eff_reg <= filter_ctl_reg[`FC_TXUT_LSB +: 2];
        if ((build_rx_tag_insert != 0) && new_on)
            rxti_eff_reg <= filter_ctl_reg[`FC_RXTI_LSB +: 2];
        if ((build_tx_tag_insert != 0) && new_on)
            txti_eff_reg <= filter_ctl_reg[`FC_TXTI_LSB +: 2];
    end
end

assign accept_bad_frames_o        = bad_eff_reg;
assign drop_all_broadcast_o       = bcst_eff_reg;
assign drop_all_group_frames_o    = grp_eff_reg;
assign extended_group_filter_on_o = ext_eff_reg;
assign rx_untag_select_o          = rxut_eff_reg;
assign tx_untag_select_o          = txut_eff_reg;
assign rx_tag_insert_select_o     = rxti_eff_reg;
assign tx_tag_insert_select_o     = txti_eff_reg;
assign rx_vlan_tag_value_o        = rx_tag_reg;
assign tx_vlan_tag_value_o        = tx_tag_reg;
assign tag_protocol_id_a_o        = tpid_a_reg;
assign tag_protocol_id_b_o        = tpid_b_reg;
assign tx_pause_value_o           = pause_val_reg[15:0];

endmodule

/* bench/table_model.sv */
`timescale 1ns/1ps
module table_model (
    input  wire        clock_i,
    input  wire [2:0]  sel_i,
    input  wire [15:0] addr_i,
    input  wire [31:0] wdata_i,
    input  wire        we_i,
    output wire [31:0] rdata_o
);
    reg [31:0] mem [0:7];
    // Idle port shows a moving pattern, never stale data
    assign rdata_o = (sel_i == 3'h0) ? {16'h0, addr_i} : mem[addr_i[2:0]];
    // Store on the one-cycle write strobe
    always @(posedge clock_i) begin
        if (we_i) begin
            mem[addr_i[2:0]] <= wdata_i;
        end
    end
endmodule

/* bench/mac_regmap_assertions.sv */
`timescale 1ns/1ps
module mac_regmap_checker (
    input wire        clock_i,
    input wire        reset_n_i,
    input wire [1:0]  s_axi_bresp_o,
    input wire [1:0]  s_axi_rresp_o,
    input wire        s_axi_bvalid_o,
    input wire        s_axi_rvalid_o,
    input wire        s_axi_rready_i,
    input wire [31:0] s_axi_rdata_o,
    input wire        accept_bad_frames_o,
    input wire        drop_all_broadcast_o,
    input wire        drop_all_group_frames_o,
    input wire [1:0]  rx_untag_select_o,
    input wire [2:0]  table_sel_o,
    input wire        table_we_o,
    input wire        tx_pause_write_o
);
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (!reset_n_i);
    // Controls move only after a completed register write
    property p_bad;
        $changed(accept_bad_frames_o) |-> $past(s_axi_bvalid_o);
    endproperty
    a_bad: assert property (p_bad) else $error("bad frame control moved");
    property p_bcst;
        $changed(drop_all_broadcast_o) |-> $past(s_axi_bvalid_o);
    endproperty
    a_bcst: assert property (p_bcst) else $error("broadcast control moved");
    property p_grp;
        $changed(drop_all_group_frames_o) |-> $past(s_axi_bvalid_o);
    endproperty
    a_grp: assert property (p_grp) else $error("group control moved");
    property p_okay;
        (s_axi_bvalid_o || s_axi_rvalid_o) |-> (s_axi_bresp_o | s_axi_rresp_o) == 2'h0;
    endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    // Read answer holds until it is accepted
    property p_rhold;
        s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped");
    property p_untag;
        rx_untag_select_o != 2'h2;
    endproperty
    a_untag: assert property (p_untag) else $error("reserved untag code out");
    property p_pause;
        tx_pause_write_o |-> s_axi_bvalid_o ##1 !tx_pause_write_o;
    endproperty
    a_pause: assert property (p_pause) else $error("pause pulse wrong");
    property p_tbl;
        table_we_o |-> s_axi_bvalid_o && table_sel_o != 3'h1;
    endproperty
    a_tbl: assert property (p_tbl) else $error("table write wrong");
    c_wr: cover property (s_axi_bvalid_o);
    c_rd: cover property (s_axi_rvalid_o);
    c_tbl: cover property (table_we_o);
endmodule
bind mac_register_map_and_rx_filter_ctl mac_regmap_checker mac_regmap_checker_i (.*);

/* bench/tb.sv */
`timescale 1ns/1ps
module tb;
    localparam [31:0] BASE = 32'h00040000;
    reg         clock_i = 1'b0, reset_n_i = 1'b0;
    reg  [31:0] s_axi_awaddr_i = 32'h0, s_axi_wdata_i = 32'h0, s_axi_araddr_i = 32'h0;
    reg         s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    reg         s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
    reg  [3:0]  s_axi_wstrb_i = 4'hf;
    reg  [31:0] serdes_pcs_status_i = 32'h0, mgmt_read_data_i = 32'h0000beef;
    reg  [29:0] mode_status_i = 30'h12345678;
    wire        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
    wire        s_axi_rvalid_o, table_we_o, tx_pause_write_o, accept_bad_frames_o;
    wire        drop_all_broadcast_o, drop_all_group_frames_o, extended_group_filter_on_o;
    wire [1:0]  s_axi_bresp_o, s_axi_rresp_o, rx_untag_select_o, tx_untag_select_o;
    wire [1:0]  rx_tag_insert_select_o, tx_tag_insert_select_o;
    wire [2:0]  table_sel_o;
    wire [15:0] table_addr_o, tx_pause_value_o;
    wire [31:0] s_axi_rdata_o, table_wdata_o, table_rdata_i, rx_vlan_tag_value_o;
    wire [31:0] tx_vlan_tag_value_o, tag_protocol_id_a_o, tag_protocol_id_b_o;
    wire [3:0]  hs = {s_axi_rvalid_o, s_axi_arready_o, s_axi_bvalid_o, s_axi_awready_o};
    reg  [31:0] got;
    reg  [1:0]  u;
    integer     mismatches = 0, n_checks = 0, k;
    mac_register_map_and_rx_filter_ctl #(.map_base_param(BASE), .build_rx_untag(1),
        .build_tx_untag(1), .build_rx_tag_insert(1), .build_tx_tag_insert(1),
        .build_extended_group_filter(1)) mac_register_map_and_rx_filter_ctl_i (.*);
    table_model table_model_i (.clock_i(clock_i), .sel_i(table_sel_o), .addr_i(table_addr_o),
        .wdata_i(table_wdata_o), .we_i(table_we_o), .rdata_o(table_rdata_i));
    always #50 clock_i = ~clock_i;
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
            end
        end
    endtask
    // Ready is settled at the falling edge, so no race with the taking edge
    task await(input integer s);
        integer n;
        begin
            n = 0;
            @(negedge clock_i);
            while (hs[s] !== 1'b1 && n < 50) begin
                n = n + 1;
                @(negedge clock_i);
            end
            if (hs[s] !== 1'b1) begin
                chk(32'h0, 32'h1);
                end_of_test;
            end
            got = s_axi_rdata_o;
            @(posedge clock_i);
        end
    endtask
    task wr(input [17:0] off, input [31:0] d);
        begin
            s_axi_awaddr_i <= BASE + off;
            s_axi_wdata_i <= d;
            {s_axi_awvalid_i, s_axi_wvalid_i} <= 2'b11;
            await(0);
            {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'b001;
            await(1);
            s_axi_bready_i <= 1'b0;
        end
    endtask
    task rc(input [17:0] off, input [31:0] exp);
        begin
            s_axi_araddr_i <= BASE + off;
            s_axi_arvalid_i <= 1'b1;
            await(2);
            {s_axi_arvalid_i, s_axi_rready_i} <= 2'b01;
            await(3);
            s_axi_rready_i <= 1'b0;
            chk(got, exp);
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", n_checks, mismatches);
            if (mismatches == 0 && n_checks > 0) begin
                $display("All tests passed");
            end else begin
                $display("Some tests failed");
            end
            $finish;
        end
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge clock_i);
        reset_n_i <= 1'b1;
        rc(18'h0, 32'h0);
        wr(18'h28, 32'h000088a8);
        wr(18'h2c, 32'h00008100);
        wr(18'h4000, 32'h00000001);
        wr(18'h8000, 32'h00000001);
        chk({tag_protocol_id_a_o[15:0], tag_protocol_id_b_o[15:0]}, 32'h88a88100);
        wr(18'h0, 32'hffffffff);
        rc(18'h0, 32'h00005ffe);
        chk({accept_bad_frames_o, drop_all_broadcast_o, drop_all_group_frames_o}, 3'h7);
        chk(extended_group_filter_on_o, 1'b1);
        $display("test filter done");
        wr(18'h708, 32'h00000001);
        for (k = 0; k < 4; k = k + 1) begin
            wr(18'h0, 32'h800 | (k * 32'h2a8));
            rc(18'h0, 32'h800 | (k * 32'h2a8));
            u = (k == 2) ? 2'h0 : k;
            chk({rx_untag_select_o, tx_untag_select_o}, {u, u});
            chk({rx_tag_insert_select_o, tx_tag_insert_select_o}, k * 5);
        end
        wr(18'h0, 32'h000077fe);
        rc(18'h0, 32'h000057fe);
        chk({extended_group_filter_on_o, rx_tag_insert_select_o}, 3'h0);
        $display("test vlan done");
        wr(18'h34, 32'hffffffff);
        rc(18'h34, 32'h0);
        wr(18'h50c, 32'h12345678);
        rc(18'h50c, 32'h0000beef);
        wr(18'h410, 32'hffffffff);
        rc(18'h410, 32'hd2345678);
        wr(18'h4, 32'h0001abcd);
        rc(18'h4, 32'h0000abcd);
        chk(tx_pause_value_o, 16'habcd);
        wr(18'h1c, 32'h0000a5a5);
        chk({rx_vlan_tag_value_o[15:0], tx_vlan_tag_value_o[15:0]}, 32'ha5a50000);
        wr(18'h500, 32'h00000041);
        rc(18'h500, 32'h00000041);
        wr(18'h20000, 32'hcafe0001);
        wr(18'h3fffc, 32'h5a5a5a5a);
        rc(18'h20000, 32'hcafe0001);
        rc(18'h3fffc, 32'h5a5a5a5a);
        $display("test map done");
        end_of_test;
    end
endmodule
